// *** hw/nrf_pkg.sv ***
// nrf_pkg: constants, types and shared functions of the nibble register file.
// assumes one core clock and a core that issues at most one access per cycle.
package nrf_pkg;
    localparam int           NRF_RF_SIZE    = 128;
    localparam int           NRF_CTRL_N     = 64;
    localparam int           NRF_DM_N       = 256;
    localparam int           NRF_SYS_N      = 12;
    localparam logic [6:0]   NRF_CTRL_LAST  = 7'h3F;
    localparam logic [6:0]   NRF_ALIAS_LO   = 7'h40;
    localparam logic [6:0]   NRF_SYS_FIRST  = 7'h74;
    localparam logic [6:0]   NRF_WIN_ADDR   = 7'h78;
    localparam logic [6:0]   NRF_BANK_ADDR  = 7'h79;
    localparam logic [6:0]   NRF_IX_ADDR    = 7'h7A;
    localparam logic [6:0]   NRF_RP_ADDR    = 7'h7D;
    localparam logic [3:0]   NRF_AR_IDX     = 4'h0;
    localparam logic [3:0]   NRF_WIN_IDX    = 4'(NRF_WIN_ADDR - NRF_SYS_FIRST);
    localparam logic [3:0]   NRF_BANK_IDX   = 4'(NRF_BANK_ADDR - NRF_SYS_FIRST);
    localparam logic [3:0]   NRF_IX_IDX     = 4'(NRF_IX_ADDR - NRF_SYS_FIRST);
    localparam logic [3:0]   NRF_RP_IDX     = 4'(NRF_RP_ADDR - NRF_SYS_FIRST);
    localparam logic [15:0]  NRF_AR_MASK    = 16'h03FF;
    localparam logic [15:0]  NRF_IX_MASK    = 16'h07FF;
    localparam logic [3:0]   NRF_BANK_MASK  = 4'h1;
    localparam logic [3:0]   NRF_NIB_RST    = 4'h0;
    localparam logic [63:0]  NRF_CTRL_USED  = 64'h0000_000F_001E_07FF;
    localparam logic [63:0]  NRF_CTRL_RO    = 64'h0000_0008_0010_0400;
    localparam logic [255:0] NRF_CTRL_WMASK =
        256'h0000_0000_0000_0000_0000_0000_0000_FFFF_0000_0000_0000_FFFF_0000_0000_0FF7_76F9;

    typedef enum logic [2:0] {
        NRF_DM_RD, NRF_DM_WR, NRF_FILE_RD, NRF_FILE_WR,
        NRF_GR_RD, NRF_GR_WR, NRF_INC_AR, NRF_INC_IX
    } nrf_op_e;
    typedef enum logic [1:0] {TGT_NONE, TGT_DM, TGT_SYS, TGT_CTRL} nrf_kind_e;
    typedef struct packed {
        logic       valid;
        nrf_op_e    op;
        logic [6:0] addr;
        logic [3:0] wdata;
    } nrf_req_s;
    typedef struct packed {
        logic       ack;
        logic [3:0] rdata;
    } nrf_rsp_s;
    typedef struct packed {
        nrf_kind_e  kind;
        logic [7:0] idx;
    } nrf_tgt_s;

    // implemented bits of each system nibble; the rest are tied to zero
    function automatic logic [3:0] nrf_sys_mask(input logic [3:0] i);
        int k;
        k = int'(i);
        if (k <= 3)
            return NRF_AR_MASK[4*(3-k)+:4];
        else if (k == int'(NRF_BANK_IDX))
            return NRF_BANK_MASK;
        else if (k >= int'(NRF_IX_IDX) && k <= int'(NRF_IX_IDX) + 2)
            return NRF_IX_MASK[4*(int'(NRF_IX_IDX)+2-k)+:4];
        else
            return 4'hF;
    endfunction

    function automatic logic [3:0] nrf_ctrl_mask(input logic [5:0] i);
        return NRF_CTRL_WMASK[4*int'(i)+:4];
    endfunction
endpackage

// *** hw/nrf_addr_map.sv ***
// nrf_addr_map: resolves an access to control, system or banked data storage.
// assumes the request and pointers come from logic on the same clock.
`timescale 1ns/1ps
module nrf_addr_map
    import nrf_pkg::*;
(
    input  nrf_pkg::nrf_req_s req,
    input  wire logic         bank,
    input  wire logic [3:0]   row_ptr,
    output nrf_pkg::nrf_tgt_s tgt
);
    logic [6:0] a;
    logic       b;
    logic       dm_space;

    always_comb
    begin
        a        = req.addr;
        b        = bank;
        dm_space = 1'b1;
        tgt      = '{kind: TGT_NONE, idx: 8'h00};
        unique case (req.op)
            NRF_GR_RD, NRF_GR_WR:
            begin
                a = {row_ptr[2:0], req.addr[3:0]};
                b = row_ptr[3];
            end
            NRF_FILE_RD, NRF_FILE_WR:
            begin
                if (req.addr <= NRF_CTRL_LAST)
                begin
                    dm_space = 1'b0;
                    tgt      = '{kind: TGT_CTRL, idx: {1'b0, req.addr}};
                end
            end
            NRF_INC_AR, NRF_INC_IX:
                dm_space = 1'b0;
            default:
                a = req.addr;
        endcase
        // file ops above 3Fh land here; from 40h to 73h they follow the current bank
        if (dm_space)
        begin
            if (a >= NRF_SYS_FIRST)
                tgt = '{kind: TGT_SYS, idx: {4'h0, 4'(a - NRF_SYS_FIRST)}};
            else
                tgt = '{kind: TGT_DM, idx: {b, a}};
        end
    end
endmodule

// *** hw/nrf_ptr_inc.sv ***
// nrf_ptr_inc: increment of a pointer that has fixed-zero bits.
// assumes the pointer value already has its fixed bits at zero.
`timescale 1ns/1ps
module nrf_ptr_inc
(
    input  wire logic [15:0] val,
    input  wire logic [15:0] mask,
    output logic      [15:0] nxt
);
    // all implemented bits set: every bit goes to zero
    assign nxt = ((val & mask) == mask) ? 16'h0000 : ((val + 16'h0001) & mask);
endmodule

// *** hw/nrf_top.sv ***
// nrf_top: nibble register file with control area, banked data memory,
// system nibbles (pointers, window, bank, row pointer) and working row.
// assumes the core holds each request for one cycle and reads rsp next cycle.
`timescale 1ns/1ps
module nrf_top
    import nrf_pkg::*;
(
    input  wire logic                        core_clk,
    input  wire logic                        reset,
    input  nrf_pkg::nrf_req_s                req,
    input  wire logic [4*nrf_pkg::NRF_CTRL_N-1:0] ro_status,
    output nrf_pkg::nrf_rsp_s                rsp,
    output logic [4*nrf_pkg::NRF_CTRL_N-1:0] ctrl_file,
    output logic                             cur_bank
);
    import nrf_pkg::*;

    logic [3:0]  dm [NRF_DM_N];
    logic [3:0]  sys [NRF_SYS_N];
    logic [3:0]  ctrl [NRF_CTRL_N];
    nrf_tgt_s    tgt;
    logic [3:0]  rd_c;
    logic [3:0]  wd_c;
    logic        we_c;
    logic        ctrl_wr_ok;
    logic [15:0] ar_val;
    logic [15:0] ix_val;
    logic [15:0] next_ar;
    logic [15:0] next_ix;
    logic [5:0]  cidx;

    assign ar_val   = {sys[NRF_AR_IDX], sys[NRF_AR_IDX+4'h1], sys[NRF_AR_IDX+4'h2], sys[NRF_AR_IDX+4'h3]};
    assign ix_val   = {4'h0, sys[NRF_IX_IDX], sys[NRF_IX_IDX+4'h1], sys[NRF_IX_IDX+4'h2]};
    assign cur_bank = sys[NRF_BANK_IDX][0];
    assign cidx     = tgt.idx[5:0];

    nrf_addr_map u_map
    (
        .req     (req),
        .bank    (cur_bank),
        .row_ptr (sys[NRF_RP_IDX]),
        .tgt     (tgt)
    );

    nrf_ptr_inc u_ar_inc
    (
        .val  (ar_val),
        .mask (NRF_AR_MASK),
        .nxt  (next_ar)
    );

    nrf_ptr_inc u_ix_inc
    (
        .val  (ix_val),
        .mask (NRF_IX_MASK),
        .nxt  (next_ix)
    );

    // read path shared by data, working row and file reads
    always_comb
    begin
        rd_c = 4'h0;
        unique case (tgt.kind)
            TGT_DM:
                rd_c = dm[tgt.idx];
            TGT_SYS:
                rd_c = sys[tgt.idx[3:0]];
            TGT_CTRL:
            begin
                // unused nibbles read zero; any value would do
                if (NRF_CTRL_USED[cidx] && NRF_CTRL_RO[cidx])
                    rd_c = ro_status[4*int'(cidx)+:4];
                else if (NRF_CTRL_USED[cidx])
                    rd_c = ctrl[cidx];
            end
            TGT_NONE:
                rd_c = 4'h0;
        endcase
    end

    always_comb
    begin
        we_c = req.valid && (req.op == NRF_DM_WR || req.op == NRF_GR_WR || req.op == NRF_FILE_WR);
        // file write takes its data from the window nibble only
        wd_c = (req.op == NRF_FILE_WR) ? sys[NRF_WIN_IDX] : req.wdata;
        ctrl_wr_ok = NRF_CTRL_USED[cidx] && !NRF_CTRL_RO[cidx];
    end

    // banked data memory; file ops from 40h to 73h share it with data ops
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < NRF_DM_N; i++)
                dm[i] <= NRF_NIB_RST;
        end
        else if (we_c && tgt.kind == TGT_DM)
        begin
            dm[tgt.idx] <= wd_c;
        end
    end

    // system nibbles: one write source per cycle, fixed bits masked off
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < NRF_SYS_N; i++)
                sys[i] <= NRF_NIB_RST;
        end
        else if (req.valid && req.op == NRF_FILE_RD)
        begin
            sys[NRF_WIN_IDX] <= rd_c;
        end
        else if (req.valid && req.op == NRF_INC_AR)
        begin
            for (int n = 0; n < 4; n++)
                sys[int'(NRF_AR_IDX)+n] <= next_ar[4*(3-n)+:4];
        end
        else if (req.valid && req.op == NRF_INC_IX)
        begin
            for (int n = 0; n < 3; n++)
                sys[int'(NRF_IX_IDX)+n] <= next_ix[4*(2-n)+:4];
        end
        else if (we_c && tgt.kind == TGT_SYS)
        begin
            sys[tgt.idx[3:0]] <= wd_c & nrf_sys_mask(tgt.idx[3:0]);
        end
    end

    // control area: no bank term anywhere, file writes only
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < NRF_CTRL_N; i++)
                ctrl[i] <= NRF_NIB_RST;
        end
        else if (we_c && tgt.kind == TGT_CTRL && ctrl_wr_ok)
        begin
            ctrl[cidx] <= wd_c & nrf_ctrl_mask(cidx);
        end
    end

    always_comb
    begin
        for (int i = 0; i < NRF_CTRL_N; i++)
            ctrl_file[4*i+:4] = ctrl[i];
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rsp <= '{ack: 1'b0, rdata: 4'h0};
        end
        else
        begin
            rsp.ack   <= req.valid;
            rsp.rdata <= rd_c;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence s_file_rd;
        req.valid && req.op == NRF_FILE_RD;
    endsequence

    sequence s_file_wr;
        req.valid && req.op == NRF_FILE_WR;
    endsequence

    sequence s_alias_wr;
        s_file_wr ##0 (req.addr >= NRF_ALIAS_LO && req.addr < NRF_SYS_FIRST);
    endsequence

    sequence s_data_wr;
        req.valid && (req.op == NRF_DM_WR || req.op == NRF_GR_WR);
    endsequence

    win_load_a: assert property (s_file_rd |=> sys[NRF_WIN_IDX] == $past(rd_c))
        else $error("window not loaded by file read");

    ctrl_store_a: assert property ((s_file_wr ##0 (tgt.kind == TGT_CTRL && ctrl_wr_ok)) |=>
        ctrl[$past(cidx)] == ($past(sys[NRF_WIN_IDX]) & nrf_ctrl_mask($past(cidx))))
        else $error("file write did not store window");

    ro_keep_a: assert property ((we_c && tgt.kind == TGT_CTRL && !ctrl_wr_ok) |=> $stable(ctrl_file))
        else $error("read-only or unused control changed");

    ctrl_fence_a: assert property (s_data_wr |=> $stable(ctrl_file))
        else $error("data op reached control area");

    alias_bank_a: assert property (s_alias_wr |=>
        dm[{$past(cur_bank), $past(req.addr)}] == $past(sys[NRF_WIN_IDX]))
        else $error("alias write missed current bank");

    ctrl_map_a: assert property ((req.valid && (req.op == NRF_FILE_RD || req.op == NRF_FILE_WR)
        && req.addr <= NRF_CTRL_LAST) |-> tgt.kind == TGT_CTRL && tgt.idx == {1'b0, req.addr})
        else $error("control address depends on bank");

    rsp_time_a: assert property (req.valid |=> rsp.ack && rsp.rdata == $past(rd_c) ##1
        (rsp.ack == $past(req.valid)))
        else $error("response not one cycle after request");

    ptr_wrap_a: assert property ((req.valid && req.op == NRF_INC_AR && ar_val == NRF_AR_MASK)
        |=> ar_val == 16'h0000)
        else $error("address pointer did not wrap");

    zero_bits_a: assert property ((sys[NRF_BANK_IDX] & ~NRF_BANK_MASK) == 4'h0
        && (ar_val & ~NRF_AR_MASK) == 16'h0000)
        else $error("fixed-zero bit became one");

    gr_read_a: assert property ((req.valid && req.op == NRF_GR_RD
        && {sys[NRF_RP_IDX][2:0], req.addr[3:0]} < NRF_SYS_FIRST)
        |=> rsp.rdata == $past(dm[{sys[NRF_RP_IDX][3], sys[NRF_RP_IDX][2:0], req.addr[3:0]}]))
        else $error("working row read wrong nibble");

    // end-to-end storage paths, pointer steps and port rules, one property each
    sequence s_alias_rd;
        s_file_rd ##0 (req.addr >= NRF_ALIAS_LO && req.addr < NRF_SYS_FIRST);
    endsequence

    sequence s_ctrl_rd;
        s_file_rd ##0 (req.addr <= NRF_CTRL_LAST);
    endsequence

    dm_write_a: assert property (
        (req.valid && req.op == NRF_DM_WR && req.addr < NRF_SYS_FIRST)
        |=> dm[$past({cur_bank, req.addr})] == $past(req.wdata))
        else $error("data write missed current bank");

    alias_read_a: assert property (
        (s_alias_rd)
        |=> sys[NRF_WIN_IDX] == $past(dm[{cur_bank, req.addr}]))
        else $error("alias read missed data memory");

    win_write_a: assert property (
        (req.valid && req.op == NRF_DM_WR && req.addr == NRF_WIN_ADDR)
        |=> sys[NRF_WIN_IDX] == $past(req.wdata))
        else $error("window nibble not written");

    file_span_a: assert property (
        (s_file_wr ##0 (req.addr >= NRF_ALIAS_LO))
        |=> $stable(ctrl_file))
        else $error("upper file write reached control area");

    ctrl_read_a: assert property (
        (s_ctrl_rd ##0 (NRF_CTRL_USED[req.addr[5:0]] && !NRF_CTRL_RO[req.addr[5:0]]))
        |=> sys[NRF_WIN_IDX] == $past(ctrl[req.addr[5:0]]))
        else $error("control read returned wrong nibble");

    ro_read_a: assert property (
        (s_ctrl_rd ##0 (NRF_CTRL_RO[req.addr[5:0]]))
        |=> sys[NRF_WIN_IDX] == $past(ro_status[4*int'(req.addr[5:0])+:4]))
        else $error("read-only status not returned");

    ix_wrap_a: assert property (
        (req.valid && req.op == NRF_INC_IX && ix_val == NRF_IX_MASK)
        |=> ix_val == 16'h0000)
        else $error("index pointer did not wrap");

    ar_step_a: assert property (
        (req.valid && req.op == NRF_INC_AR && ar_val != NRF_AR_MASK)
        |=> ar_val == (($past(ar_val) + 16'h0001) & NRF_AR_MASK))
        else $error("address pointer step wrong");

    ix_zero_a: assert property (
        (ix_val & ~NRF_IX_MASK) == 16'h0000
        && sys[NRF_AR_IDX] == 4'h0)
        else $error("pointer fixed-zero bit became one");

    sys_mask_a: assert property (
        (we_c && tgt.kind == TGT_SYS)
        |=> sys[$past(tgt.idx[3:0])] == ($past(wd_c) & nrf_sys_mask($past(tgt.idx[3:0]))))
        else $error("system write not masked");

    addr_form_a: assert property (
        (req.valid && (req.op == NRF_DM_RD || req.op == NRF_DM_WR) && req.addr < NRF_SYS_FIRST)
        |-> tgt.kind == TGT_DM && tgt.idx == {cur_bank, req.addr[6:4], req.addr[3:0]})
        else $error("row and column resolved wrongly");

    ctrl_idx_a: assert property (
        (tgt.kind == TGT_CTRL)
        |-> tgt.idx[7:6] == 2'b00 && req.addr <= NRF_CTRL_LAST)
        else $error("control index out of range");

    data_rd_a: assert property (
        (req.valid && req.op == NRF_DM_RD && req.addr <= NRF_CTRL_LAST)
        |-> tgt.kind == TGT_DM)
        else $error("data read reached control area");

    gr_write_a: assert property (
        (req.valid && req.op == NRF_GR_WR && {sys[NRF_RP_IDX][2:0], req.addr[3:0]} < NRF_SYS_FIRST)
        |=> dm[$past({sys[NRF_RP_IDX], req.addr[3:0]})] == $past(req.wdata))
        else $error("working row write wrong nibble");

    ack_idle_a: assert property (
        (!req.valid)
        |=> !rsp.ack)
        else $error("acknowledge without request");

    inc_fence_a: assert property (
        (req.valid && (req.op == NRF_INC_AR || req.op == NRF_INC_IX))
        |=> $stable(ctrl_file))
        else $error("pointer step reached control area");
endmodule

// *** verification/nrf_core_model.sv ***
// nrf_core_model: core side of the request port, one access per call.
// assumes the core clock and a request that is taken at the next rising edge.
`timescale 1ns/1ps
module nrf_core_model
    import nrf_pkg::*;
(
    input  wire logic         core_clk,
    output nrf_pkg::nrf_req_s req,
    input  nrf_pkg::nrf_rsp_s rsp
);
    initial req = '0;

    // valid stays up from call to call; each call is taken at exactly one edge
    task automatic access(input nrf_op_e o, input logic [6:0] a, input logic [3:0] d,
                          output logic [3:0] q, output logic k);
        req.valid = 1'b1;
        req.op    = o;
        req.addr  = a;
        req.wdata = d;
        @(posedge core_clk);
        #1;
        q         = rsp.rdata;
        k         = rsp.ack;
    endtask

    // port goes quiet once the last request has been taken
    task automatic idle();
        req.valid = 1'b0;
    endtask
endmodule

// *** verification/nibble_register_file_access_tb_top.sv ***
// nibble_register_file_access_tb_top: directed bench of the register file.
// assumes nrf_top with its core port driven by nrf_core_model.
`timescale 1ns/1ps
module nibble_register_file_access_tb_top;
    import nrf_pkg::*;
    logic                            core_clk;
    logic                            reset;
    logic [4*NRF_CTRL_N-1:0]         ro_status;
    logic [4*NRF_CTRL_N-1:0]         ctrl_file;
    logic                            cur_bank;
    nrf_req_s                        req;
    nrf_rsp_s                        rsp;
    logic [3:0]                      q;
    logic                            k;
    logic [3:0]                      exp_n;
    int                              n_mismatch;
    int                              checked;
    int                              cycles;

    nrf_top DUT (.core_clk(core_clk), .reset(reset), .req(req), .ro_status(ro_status),
                 .rsp(rsp), .ctrl_file(ctrl_file), .cur_bank(cur_bank));
    nrf_core_model core (.core_clk(core_clk), .req(req), .rsp(rsp));

    initial core_clk = 1'b0;
    always #12.5 core_clk = ~core_clk;

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // hang guard: the whole sequence needs well under 400 cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic chk(input string what, input logic [3:0] e, input logic [3:0] got);
        checked++;
        if (got !== e)
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, e, got);
        end
    endtask

    task automatic op(input nrf_op_e o, input logic [6:0] a, input logic [3:0] d);
        core.access(o, a, d, q, k);
        chk("ack", 4'h1, {3'h0, k});
    endtask

    task automatic rd(input nrf_op_e o, input logic [6:0] a, input logic [3:0] e);
        op(o, a, 4'h0);
        chk($sformatf("read of %h", a), e, q);
    endtask

    // fill a pointer with ones, check its fixed-zero bits, step it and expect zero
    task automatic wrap(input logic [6:0] base, input int n, input logic [15:0] m, input nrf_op_e inc);
        for (int i = 0; i < n; i++)
            op(NRF_DM_WR, base + 7'(i), 4'hF);
        for (int i = 0; i < n; i++)
            rd(NRF_DM_RD, base + 7'(i), m[4*(n-1-i)+:4]);
        op(inc, 7'h00, 4'h0);
        for (int i = 0; i < n; i++)
            rd(NRF_DM_RD, base + 7'(i), 4'h0);
    endtask

    initial
    begin
        reset     = 1'b1;
        ro_status = {NRF_CTRL_N{4'h9}};
        repeat (6) @(posedge core_clk);
        #1;
        reset = 1'b0;
        chk("cur_bank", 4'h0, {3'h0, cur_bank});
        chk("ctrl_file", 4'h0, {3'h0, |ctrl_file});
        chk("rsp ack", 4'h0, {3'h0, rsp.ack});
        $display("test reset done");
        @(posedge core_clk);
        #1;

        exp_n = NRF_CTRL_WMASK[4*18+:4];
        op(NRF_DM_WR, NRF_WIN_ADDR, 4'hF);
        op(NRF_FILE_WR, 7'h12, 4'h0);
        chk("ctrl 12", exp_n, ctrl_file[4*18+:4]);
        op(NRF_DM_WR, NRF_WIN_ADDR, 4'h0);
        rd(NRF_FILE_RD, 7'h12, exp_n);
        rd(NRF_DM_RD, NRF_WIN_ADDR, exp_n);
        op(NRF_DM_WR, 7'h12, 4'h0);
        chk("ctrl 12", exp_n, ctrl_file[4*18+:4]);
        $display("test file transfer done");

        op(NRF_DM_WR, NRF_WIN_ADDR, 4'h6);
        op(NRF_FILE_WR, 7'h0A, 4'h0);
        rd(NRF_FILE_RD, 7'h0A, 4'h9);
        op(NRF_FILE_WR, 7'h30, 4'h0);
        chk("ctrl 30", 4'h0, ctrl_file[4*48+:4]);
        op(NRF_FILE_WR, 7'h23, 4'h0);
        chk("ctrl 23", 4'h0, ctrl_file[4*35+:4]);
        $display("test read-only done");

        op(NRF_DM_WR, 7'h45, 4'hA);
        op(NRF_DM_WR, NRF_BANK_ADDR, 4'hF);
        rd(NRF_DM_RD, NRF_BANK_ADDR, 4'h1);
        chk("cur_bank", 4'h1, {3'h0, cur_bank});
        op(NRF_DM_WR, 7'h45, 4'h5);
        rd(NRF_FILE_RD, 7'h45, 4'h5);
        rd(NRF_FILE_RD, 7'h12, exp_n);
        op(NRF_FILE_WR, 7'h46, 4'h0);
        rd(NRF_DM_RD, 7'h46, exp_n);
        op(NRF_DM_WR, NRF_BANK_ADDR, 4'h0);
        rd(NRF_FILE_RD, 7'h45, 4'hA);
        $display("test bank alias done");

        wrap(NRF_SYS_FIRST, 4, NRF_AR_MASK, NRF_INC_AR);
        wrap(NRF_IX_ADDR, 3, NRF_IX_MASK, NRF_INC_IX);
        $display("test pointer wrap done");

        op(NRF_DM_WR, NRF_RP_ADDR, 4'h2);
        op(NRF_GR_WR, 7'h05, 4'hC);
        rd(NRF_DM_RD, 7'h25, 4'hC);
        op(NRF_DM_WR, NRF_RP_ADDR, 4'hF);
        op(NRF_GR_WR, 7'h01, 4'h6);
        rd(NRF_GR_RD, 7'h01, 4'h6);
        op(NRF_DM_WR, NRF_BANK_ADDR, 4'h1);
        rd(NRF_DM_RD, 7'h71, 4'h6);
        rd(NRF_FILE_RD, 7'h71, 4'h6);
        op(NRF_DM_WR, NRF_BANK_ADDR, 4'h0);
        rd(NRF_FILE_RD, 7'h25, 4'h0);
        rd(NRF_DM_RD, 7'h25, 4'hC);
        $display("test working row done");
        core.idle();
        print_verdict();
    end
endmodule
